// *** verification/tb_top.sv ***
// self-checking testbench for the cpu error report and recovery block
`timescale 1ns/1ps
module tb_top;
    logic core_clk, reset_n, hsel, hwrite, extErrIn, fillIsDemand, fillLocked, fillFirstQw;
    logic bcIndexMatch, bcReadUncorr;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, fillAddrIn, busErrAddrIn, bcReadData, rd;
    logic [7:0] fillSyndromeIn;
    logic [13:0] ev;
    wire hreadyout, hresp, forceHitValid, bcacheEnable, forceHitMode, pcacheEnable, vicEnable;
    wire vicInvalidate, tbInvalidateAll, tbInvalidateSingle, tbFlushProcess, machineCheck, hardErrIrq, softErrIrq;
    wire [31:0] hrdata, forceHitData, tbInvalidateAddr;
    wire [1:0] notifyLevel;
    // one bit per event pulse so a single task can raise any of them
    wire fillEccEvt = ev[0];
    wire bcReadDone = ev[1];
    wire bcTagParityEvt = ev[2];
    wire busWriteErrEvt = ev[3];
    wire busReadErrEvt = ev[4];
    wire pcTagErrEvt = ev[5];
    wire pcDataErrEvt = ev[6];
    wire pteReadErrEvt = ev[7];
    wire tbParityEvt = ev[8];
    wire vicTagErrEvt = ev[9];
    wire vicDataErrEvt = ev[10];
    wire returnFromInterrupt = ev[11];
    wire loadProcessContext = ev[12];
    wire bcMemRead = ev[13];
    int errors, check_count, cyc, nAll, nOne, nVic, nProc;

    cer_error_unit DUT (.core_clk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready(hreadyout), .hreadyout, .hrdata, .hresp, .fillEccEvt, .fillIsDemand, .fillLocked,
        .fillFirstQw, .fillAddrIn, .fillSyndromeIn, .bcReadDone, .bcTagParityEvt, .busWriteErrEvt,
        .busReadErrEvt, .busErrAddrIn, .extErrIn, .pcTagErrEvt, .pcDataErrEvt, .pteReadErrEvt,
        .tbParityEvt, .vicTagErrEvt, .vicDataErrEvt, .returnFromInterrupt, .loadProcessContext,
        .bcMemRead, .bcIndexMatch, .bcReadUncorr, .bcReadData, .forceHitValid, .forceHitData,
        .bcacheEnable, .forceHitMode, .pcacheEnable, .vicEnable, .vicInvalidate, .tbInvalidateAll,
        .tbInvalidateSingle, .tbInvalidateAddr, .tbFlushProcess, .machineCheck, .hardErrIrq,
        .softErrIrq, .notifyLevel);

    initial begin
        core_clk = 0;
        forever #2.5 core_clk = ~core_clk;
    end

    task give_verdict;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // pulse counters sample the flop outputs, so the exact pulse cycle need not be known
    always @(posedge core_clk) begin
        cyc++;
        nAll += tbInvalidateAll;
        nOne += tbInvalidateSingle;
        nVic += vicInvalidate;
        nProc += tbFlushProcess;
        if (cyc == 20000) begin
            errors++;
            give_verdict();
        end
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // ready is sampled at the rising edge, and read data is taken at that same edge
    task wait_rdy;
        do @(posedge core_clk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        wait_rdy();
        hsel <= 0;
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        // a write lands at this edge; step off it so callers see the settled outputs
        #1;
    endtask

    task rdchk(input string nm, input logic [31:0] a, input logic [31:0] e);
        bus(0, a, 32'h0);
        chk(nm, rd, e);
        chk("hresp", hresp, 32'h0);
    endtask

    task pulse(input int i);
        @(posedge core_clk);
        ev[i] <= 1;
        @(posedge core_clk);
        ev[i] <= 0;
        #1;
    endtask

    task t_reset;
        rdchk("bes", 32'h00, 32'h0);
        rdchk("bcc", 32'h04, 32'h0);
        rdchk("pcs", 32'h14, 32'h0);
        rdchk("pcc", 32'h18, 32'h0);
        rdchk("tbs", 32'h1C, 32'h0);
        rdchk("ics", 32'h20, 32'h0);
        bus(1, 32'h40, 32'hFFFF_FFFF);
        rdchk("unmapped", 32'h40, 32'h0);
    endtask

    task t_fill;
        fillIsDemand <= 1;
        fillAddrIn <= 32'h1234_5678;
        fillSyndromeIn <= 8'h5A;
        pulse(0);
        chk("mc", machineCheck, 1);
        chk("soft", softErrIrq, 1);
        chk("lvl", notifyLevel, cer_pkg::LVL_MCHK);
        @(posedge core_clk);
        #1;
        chk("lvl", notifyLevel, cer_pkg::LVL_SOFT);
        fillAddrIn <= 32'h9ABC_DEF0;
        fillSyndromeIn <= 8'hA5;
        pulse(0);
        rdchk("bes", 32'h00, 32'h11);
        rdchk("faddr", 32'h0C, 32'h1234_5678);
        rdchk("fsyn", 32'h10, 32'h5A);
        bus(1, 32'h00, 32'h0);
        rdchk("bes", 32'h00, 32'h11);
        bus(1, 32'h00, 32'h01);
        rdchk("bes", 32'h00, 32'h10);
        bus(1, 32'h00, 32'h10);
        rdchk("bes", 32'h00, 32'h0);
        chk("soft", softErrIrq, 0);
    endtask

    task t_hard;
        busErrAddrIn <= 32'h0000_1000;
        pulse(3);
        chk("mc", machineCheck, 0);
        chk("soft", softErrIrq, 0);
        chk("lvl", notifyLevel, cer_pkg::LVL_HARD);
        repeat (6) @(posedge core_clk);
        #1;
        chk("hard", hardErrIrq, 1);
        busErrAddrIn <= 32'h0000_2000;
        pulse(4);
        chk("mc", machineCheck, 1);
        rdchk("bes", 32'h00, 32'h1C);
        rdchk("baddr", 32'h08, 32'h0000_1000);
        bus(1, 32'h00, 32'h1C);
        rdchk("bes", 32'h00, 32'h0);
        chk("hard", hardErrIrq, 0);
    endtask

    task t_lock;
        fillLocked <= 1;
        fillFirstQw <= 0;
        pulse(0);
        chk("mc", machineCheck, 0);
        fillFirstQw <= 1;
        pulse(0);
        chk("mc", machineCheck, 1);
        fillLocked <= 0;
        bus(1, 32'h00, 32'h1F);
    endtask

    task t_caches;
        // software order: backup, primary, tb flush, instruction cache
        bus(1, 32'h04, 32'h1);
        bus(1, 32'h18, 32'h1);
        bus(1, 32'h24, 32'h0);
        bus(1, 32'h20, 32'h1);
        chk("en", {bcacheEnable, pcacheEnable, vicEnable}, 3'b111);
        pulse(5);
        chk("pcen", pcacheEnable, 0);
        pulse(6);
        pulse(7);
        rdchk("pcs", 32'h14, 32'h7);
        bus(1, 32'h14, 32'h4);
        rdchk("pcs", 32'h14, 32'h3);
        bus(1, 32'h14, 32'h3);
        rdchk("pcs", 32'h14, 32'h0);
        pulse(9);
        chk("vicen", vicEnable, 0);
        pulse(10);
        rdchk("ics", 32'h20, 32'h6);
        bus(1, 32'h20, 32'h2);
        rdchk("ics", 32'h20, 32'h4);
        bus(1, 32'h20, 32'h4);
        rdchk("ics", 32'h20, 32'h0);
        pulse(2);
        chk("bcen", bcacheEnable, 0);
        bus(1, 32'h00, 32'h02);
        rdchk("bes", 32'h00, 32'h0);
    endtask

    task t_tb;
        int a;
        a = nAll;
        pulse(8);
        chk("mc", machineCheck, 1);
        step2();
        chk("inval", nAll - a, 1);
        rdchk("tbs", 32'h1C, 32'h1);
        bus(1, 32'h1C, 32'h0);
        rdchk("tbs", 32'h1C, 32'h1);
        bus(1, 32'h1C, 32'h1);
        rdchk("tbs", 32'h1C, 32'h0);
        bus(1, 32'h24, 32'h0);
        bus(1, 32'h28, 32'hCAFE_0000);
        pulse(12);
        pulse(11);
        step2();
        chk("inval", nAll - a, 2);
        chk("one", nOne, 1);
        chk("oneaddr", tbInvalidateAddr, 32'hCAFE_0000);
        chk("proc", nProc, 1);
        chk("vicinv", nVic, 1);
    endtask

    task step2;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task t_force;
        bus(1, 32'h04, 32'h2);
        chk("fhm", forceHitMode, 1);
        bcIndexMatch <= 1;
        bcReadData <= 32'h5555_AAAA;
        pulse(13);
        chk("fhv", forceHitValid, 1);
        chk("fhd", forceHitData, 32'h5555_AAAA);
        bcReadUncorr <= 1;
        pulse(13);
        chk("fhv", forceHitValid, 0);
        bcReadUncorr <= 0;
        bcIndexMatch <= 0;
        pulse(13);
        chk("fhv", forceHitValid, 0);
        fillIsDemand <= 0;
        pulse(0);
        rdchk("bes", 32'h00, 32'h01);
        bus(1, 32'h00, 32'h01);
        bus(1, 32'h04, 32'h4);
        fillSyndromeIn <= 8'hC3;
        pulse(1);
        rdchk("fsyn", 32'h10, 32'hC3);
        fillSyndromeIn <= 8'h3C;
        pulse(1);
        rdchk("fsyn", 32'h10, 32'h3C);
    endtask

    task t_ext;
        @(posedge core_clk);
        extErrIn <= 1;
        repeat (3) @(posedge core_clk);
        #1;
        chk("hard", hardErrIrq, 1);
        repeat (5) @(posedge core_clk);
        #1;
        chk("hard", hardErrIrq, 1);
        extErrIn <= 0;
        repeat (4) @(posedge core_clk);
        #1;
        chk("hard", hardErrIrq, 0);
    endtask

    initial begin
        {reset_n, hsel, hwrite, extErrIn, fillIsDemand, fillLocked, fillFirstQw} = 0;
        {bcIndexMatch, bcReadUncorr, htrans, ev, haddr, hwdata} = 0;
        {fillAddrIn, busErrAddrIn, bcReadData, fillSyndromeIn} = 0;
        hsize = 3'h2;
        repeat (4) @(posedge core_clk);
        reset_n <= 1;
        t_reset();
        t_fill();
        t_hard();
        t_lock();
        t_caches();
        t_tb();
        t_force();
        t_ext();
        give_verdict();
    end
endmodule

// *** verilog/cer_error_unit.sv ***
// error latching, notification and cache recovery control with ahb-lite registers
`timescale 1ns/1ps
module cer_error_unit (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // backup cache and bus error events
    input wire logic fillEccEvt,
    input wire logic fillIsDemand,
    input wire logic fillLocked,
    input wire logic fillFirstQw,
    input wire logic [31:0] fillAddrIn,
    input wire logic [7:0] fillSyndromeIn,
    input wire logic bcReadDone,
    input wire logic bcTagParityEvt,
    input wire logic busWriteErrEvt,
    input wire logic busReadErrEvt,
    input wire logic [31:0] busErrAddrIn,
    input wire logic extErrIn,
    // core cache and translation events
    input wire logic pcTagErrEvt,
    input wire logic pcDataErrEvt,
    input wire logic pteReadErrEvt,
    input wire logic tbParityEvt,
    input wire logic vicTagErrEvt,
    input wire logic vicDataErrEvt,
    input wire logic returnFromInterrupt,
    input wire logic loadProcessContext,
    // forced hit read path
    input wire logic bcMemRead,
    input wire logic bcIndexMatch,
    input wire logic bcReadUncorr,
    input wire logic [31:0] bcReadData,
    output logic forceHitValid,
    output logic [31:0] forceHitData,
    // cache control outputs
    output logic bcacheEnable,
    output logic forceHitMode,
    output logic pcacheEnable,
    output logic vicEnable,
    output logic vicInvalidate,
    output logic tbInvalidateAll,
    output logic tbInvalidateSingle,
    output logic [31:0] tbInvalidateAddr,
    output logic tbFlushProcess,
    // notifications
    output logic machineCheck,
    output logic hardErrIrq,
    output logic softErrIrq,
    output logic [1:0] notifyLevel
);
    typedef struct packed {
        logic [cer_pkg::BES_W-1:0] bes;
        logic [cer_pkg::BCC_W-1:0] bcc;
        logic [31:0] busAddr;
        logic [31:0] fillAddr;
        logic [7:0] syn;
        logic [cer_pkg::PCS_W-1:0] pcs;
        logic pcc;
        logic tbs;
        logic [cer_pkg::ICS_W-1:0] ics;
        logic dpValid;
        logic dpWrite;
        logic rdWait;
        logic [7:0] dpAddr;
        logic [31:0] rdata;
        logic mc;
        logic vicInv;
        logic tbAll;
        logic tbOne;
        logic tbProc;
        logic [31:0] tbAddr;
        logic fhValid;
        logic [31:0] fhData;
    } cer_state_s;

    cer_state_s st;
    cer_state_s next_st;
    logic extErrSync;
    logic wrPhase;
    logic busErrLatched;
    logic busEvt;
    logic mcFill;

    function automatic logic wrHit(input logic [7:0] a, input logic [7:0] off, input logic wr);
        wrHit = wr && (a == off);
    endfunction

    function automatic logic [31:0] regRead(input cer_state_s s, input logic [7:0] a);
        case (a)
            cer_pkg::OFF_BUS_STATUS: regRead = {27'h000_0000, s.bes};
            cer_pkg::OFF_BUS_CTRL: regRead = {29'h0000_0000, s.bcc};
            cer_pkg::OFF_BUS_ADDR: regRead = s.busAddr;
            cer_pkg::OFF_FILL_ADDR: regRead = s.fillAddr;
            cer_pkg::OFF_FILL_SYN: regRead = {24'h00_0000, s.syn};
            cer_pkg::OFF_PC_STATUS: regRead = {29'h0000_0000, s.pcs};
            cer_pkg::OFF_PC_CTRL: regRead = {31'h0000_0000, s.pcc};
            cer_pkg::OFF_TB_STATUS: regRead = {31'h0000_0000, s.tbs};
            cer_pkg::OFF_IC_CSR: regRead = {29'h0000_0000, s.ics};
            default: regRead = 32'h0000_0000;
        endcase
    endfunction

    cer_sync u_ext_sync (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .asyncIn(extErrIn),
        .syncOut(extErrSync)
    );

    assign wrPhase = st.dpValid && st.dpWrite;
    assign busErrLatched = st.bes[cer_pkg::BES_FILL_ECC] || st.bes[cer_pkg::BES_TAG_PAR] ||
                           st.bes[cer_pkg::BES_WR_HARD] || st.bes[cer_pkg::BES_RD_ERR];
    assign busEvt = fillEccEvt || bcTagParityEvt || busWriteErrEvt || busReadErrEvt;
    // a locked read machine checks only on the first returned quadword
    assign mcFill = fillEccEvt && fillIsDemand && (!fillLocked || fillFirstQw);

    always_comb begin
        logic [cer_pkg::BES_W-1:0] besSet;
        logic [cer_pkg::BES_W-1:0] besClr;
        logic [cer_pkg::PCS_W-1:0] pcsSet;
        logic [cer_pkg::PCS_W-1:0] pcsClr;
        logic [cer_pkg::ICS_W-1:0] icsSet;
        logic [cer_pkg::ICS_W-1:0] icsClr;
        logic rdFirst;
        besSet = '0;
        besClr = '0;
        pcsSet = '0;
        pcsClr = '0;
        icsSet = '0;
        icsClr = '0;
        next_st = st;
        rdFirst = st.dpValid && !st.dpWrite && !st.rdWait;

        // bus slave: writes take no wait state, reads take one so hrdata comes from a flop
        if (hreadyout) begin
            next_st.dpValid = hsel && htrans[1] && hready;
            next_st.dpWrite = hwrite;
            next_st.dpAddr = haddr[7:0];
            next_st.rdWait = 1'b0;
        end
        if (rdFirst) begin
            next_st.rdata = regRead(st, st.dpAddr);
            next_st.rdWait = 1'b1;
        end

        // event capture; set wins over a clear in the same cycle
        besSet[cer_pkg::BES_FILL_ECC] = fillEccEvt;
        besSet[cer_pkg::BES_TAG_PAR] = bcTagParityEvt;
        besSet[cer_pkg::BES_WR_HARD] = busWriteErrEvt;
        besSet[cer_pkg::BES_RD_ERR] = busReadErrEvt;
        besSet[cer_pkg::BES_SEO] = busEvt && busErrLatched;
        if (wrHit(st.dpAddr, cer_pkg::OFF_BUS_STATUS, wrPhase)) begin
            besClr = hwdata[cer_pkg::BES_W-1:0];
        end
        next_st.bes = (st.bes & ~besClr) | besSet;

        // capture only the first error; later ones leave address and syndrome alone, but with suppress set each read done reloads syndrome and fill address
        if (!busErrLatched && (bcTagParityEvt || busWriteErrEvt || busReadErrEvt)) begin
            next_st.busAddr = busErrAddrIn;
        end
        if (st.bcc[cer_pkg::BCC_SUPPRESS] && bcReadDone) begin
            next_st.syn = fillSyndromeIn;
            next_st.fillAddr = fillAddrIn;
        end else if (!busErrLatched && fillEccEvt) begin
            next_st.syn = fillSyndromeIn;
            next_st.fillAddr = fillAddrIn;
        end

        pcsSet = {pteReadErrEvt, pcDataErrEvt, pcTagErrEvt};
        if (wrHit(st.dpAddr, cer_pkg::OFF_PC_STATUS, wrPhase)) begin
            pcsClr = hwdata[cer_pkg::PCS_W-1:0];
        end
        next_st.pcs = (st.pcs & ~pcsClr) | pcsSet;

        next_st.tbs = (st.tbs && !(wrHit(st.dpAddr, cer_pkg::OFF_TB_STATUS, wrPhase) && hwdata[0]))
                      || tbParityEvt;

        icsSet[cer_pkg::ICS_TAG] = vicTagErrEvt;
        icsSet[cer_pkg::ICS_DATA] = vicDataErrEvt;
        if (wrHit(st.dpAddr, cer_pkg::OFF_IC_CSR, wrPhase)) begin
            icsClr = hwdata[cer_pkg::ICS_W-1:0] & ~(3'h1 << cer_pkg::ICS_ENABLE);
            next_st.ics[cer_pkg::ICS_ENABLE] = hwdata[cer_pkg::ICS_ENABLE];
        end
        next_st.ics[cer_pkg::ICS_DATA:cer_pkg::ICS_TAG] =
            (st.ics[cer_pkg::ICS_DATA:cer_pkg::ICS_TAG] & ~icsClr[cer_pkg::ICS_DATA:cer_pkg::ICS_TAG])
            | icsSet[cer_pkg::ICS_DATA:cer_pkg::ICS_TAG];

        // control registers; a cache error turns its cache off over any enable write
        if (wrHit(st.dpAddr, cer_pkg::OFF_BUS_CTRL, wrPhase)) begin
            next_st.bcc = hwdata[cer_pkg::BCC_W-1:0];
        end
        if (wrHit(st.dpAddr, cer_pkg::OFF_PC_CTRL, wrPhase)) begin
            next_st.pcc = hwdata[0];
        end
        if (fillEccEvt || bcTagParityEvt) begin
            next_st.bcc[cer_pkg::BCC_ENABLE] = 1'b0;
        end
        if (pcTagErrEvt || pcDataErrEvt) begin
            next_st.pcc = 1'b0;
        end
        if (vicTagErrEvt || vicDataErrEvt) begin
            next_st.ics[cer_pkg::ICS_ENABLE] = 1'b0;
        end

        // translation and instruction cache maintenance pulses
        next_st.vicInv = returnFromInterrupt;
        next_st.tbProc = loadProcessContext;
        next_st.tbAll = wrHit(st.dpAddr, cer_pkg::OFF_TB_INV_ALL, wrPhase) || tbParityEvt;
        next_st.tbOne = wrHit(st.dpAddr, cer_pkg::OFF_TB_INV_ONE, wrPhase);
        if (next_st.tbOne) begin
            next_st.tbAddr = hwdata;
        end

        // machine check: demand fill errors, tb parity, read after a latched hard write
        next_st.mc = mcFill || tbParityEvt ||
                     (busReadErrEvt && st.bes[cer_pkg::BES_WR_HARD]);

        // forced hit: index match alone selects the line, uncorrectable data never returns
        next_st.fhValid = st.bcc[cer_pkg::BCC_FORCE_HIT] && bcMemRead && bcIndexMatch
                          && !bcReadUncorr;
        if (next_st.fhValid) begin
            next_st.fhData = bcReadData;
        end
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
            st.bes <= cer_pkg::BES_RESET;
            st.bcc <= cer_pkg::BCC_RESET;
            st.pcs <= cer_pkg::PCS_RESET;
            st.pcc <= cer_pkg::PCC_RESET;
            st.tbs <= cer_pkg::TBS_RESET;
            st.ics <= cer_pkg::ICS_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign hreadyout = !(st.dpValid && !st.dpWrite && !st.rdWait);
    assign hrdata = st.rdata;
    assign hresp = 1'b0;
    assign bcacheEnable = st.bcc[cer_pkg::BCC_ENABLE];
    assign forceHitMode = st.bcc[cer_pkg::BCC_FORCE_HIT];
    assign pcacheEnable = st.pcc;
    assign vicEnable = st.ics[cer_pkg::ICS_ENABLE];
    assign vicInvalidate = st.vicInv;
    assign tbInvalidateAll = st.tbAll;
    assign tbInvalidateSingle = st.tbOne;
    assign tbInvalidateAddr = st.tbAddr;
    assign tbFlushProcess = st.tbProc;
    assign forceHitValid = st.fhValid;
    assign forceHitData = st.fhData;
    assign machineCheck = st.mc;
    // level sensitive: stays up until pin drops and status is cleared
    assign hardErrIrq = extErrSync || st.bes[cer_pkg::BES_WR_HARD] || st.bes[cer_pkg::BES_RD_ERR];
    assign softErrIrq = st.bes[cer_pkg::BES_FILL_ECC] || st.bes[cer_pkg::BES_TAG_PAR] ||
                        (|st.pcs) || st.ics[cer_pkg::ICS_TAG] || st.ics[cer_pkg::ICS_DATA];
    assign notifyLevel = st.mc ? cer_pkg::LVL_MCHK :
                         hardErrIrq ? cer_pkg::LVL_HARD :
                         softErrIrq ? cer_pkg::LVL_SOFT : cer_pkg::LVL_NONE;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    chk_cache_autooff: assert property ((fillEccEvt || bcTagParityEvt) |=> !bcacheEnable)
        else $error("backup cache stayed enabled after its error");
    chk_soft_on_ecc: assert property (fillEccEvt |=> softErrIrq)
        else $error("uncorrectable fill error gave no soft error");
    chk_mc_second: assert property ((busReadErrEvt && st.bes[cer_pkg::BES_WR_HARD])
        |=> machineCheck && st.bes[cer_pkg::BES_SEO])
        else $error("read after hard write gave no machine check with second flag");
    chk_prio_order: assert property ((machineCheck |-> notifyLevel == 2'h3) and
        ((!machineCheck && hardErrIrq) |-> notifyLevel == 2'h2))
        else $error("notification priority wrong");
    chk_lock_later: assert property ((fillEccEvt && fillLocked && !fillFirstQw && !tbParityEvt
        && !busReadErrEvt) |=> !machineCheck)
        else $error("later locked quadword raised machine check");
    chk_w1c_hold: assert property ((!wrHit(st.dpAddr, cer_pkg::OFF_BUS_STATUS, wrPhase))
        |=> (st.bes & $past(st.bes)) == $past(st.bes))
        else $error("bus status bit lost without a write");
    chk_rei_flush: assert property (returnFromInterrupt |=> vicInvalidate)
        else $error("no instruction cache invalidate after return");
    chk_tb_parity: assert property (tbParityEvt |=> tbInvalidateAll ##0 st.tbs)
        else $error("tb parity did not flush translation buffer");
    chk_first_addr: assert property ((busErrLatched && busEvt) |=> $stable(st.busAddr)
        && st.bes[cer_pkg::BES_SEO])
        else $error("second error overwrote first capture");
    chk_read_wait: assert property ((st.dpValid && !st.dpWrite && !st.rdWait) |=> hreadyout)
        else $error("read data phase longer than one wait");

    cov_mchk: cover property (machineCheck);
    cov_force_hit: cover property (forceHitValid);
    cov_second: cover property (st.bes[cer_pkg::BES_SEO] && hardErrIrq);
    cov_w1c_clear: cover property (wrHit(st.dpAddr, cer_pkg::OFF_BUS_STATUS, wrPhase) ##1 st.bes == 5'h00);
endmodule

// *** verilog/cer_pkg.sv ***
// constants for the cpu error report and recovery block
package cer_pkg;
    // register byte offsets
    localparam logic [7:0] OFF_BUS_STATUS = 8'h00;
    localparam logic [7:0] OFF_BUS_CTRL = 8'h04;
    localparam logic [7:0] OFF_BUS_ADDR = 8'h08;
    localparam logic [7:0] OFF_FILL_ADDR = 8'h0C;
    localparam logic [7:0] OFF_FILL_SYN = 8'h10;
    localparam logic [7:0] OFF_PC_STATUS = 8'h14;
    localparam logic [7:0] OFF_PC_CTRL = 8'h18;
    localparam logic [7:0] OFF_TB_STATUS = 8'h1C;
    localparam logic [7:0] OFF_IC_CSR = 8'h20;
    localparam logic [7:0] OFF_TB_INV_ALL = 8'h24;
    localparam logic [7:0] OFF_TB_INV_ONE = 8'h28;
    // bus_error_status fields
    localparam int BES_FILL_ECC = 0;
    localparam int BES_TAG_PAR = 1;
    localparam int BES_WR_HARD = 2;
    localparam int BES_RD_ERR = 3;
    localparam int BES_SEO = 4;
    localparam int BES_W = 5;
    // bus_cache_control fields
    localparam int BCC_ENABLE = 0;
    localparam int BCC_FORCE_HIT = 1;
    localparam int BCC_SUPPRESS = 2;
    localparam int BCC_W = 3;
    // primary_cache_status fields
    localparam int PCS_TAG = 0;
    localparam int PCS_DATA = 1;
    localparam int PCS_PTE = 2;
    localparam int PCS_W = 3;
    // instr_cache_ctrl_status fields
    localparam int ICS_ENABLE = 0;
    localparam int ICS_TAG = 1;
    localparam int ICS_DATA = 2;
    localparam int ICS_W = 3;
    // reset values
    localparam logic [BES_W-1:0] BES_RESET = 5'h00;
    localparam logic [BCC_W-1:0] BCC_RESET = 3'h0;
    localparam logic [PCS_W-1:0] PCS_RESET = 3'h0;
    localparam logic PCC_RESET = 1'b0;
    localparam logic TBS_RESET = 1'b0;
    localparam logic [ICS_W-1:0] ICS_RESET = 3'h0;
    // notification levels, highest wins
    localparam logic [1:0] LVL_NONE = 2'h0;
    localparam logic [1:0] LVL_SOFT = 2'h1;
    localparam logic [1:0] LVL_HARD = 2'h2;
    localparam logic [1:0] LVL_MCHK = 2'h3;
endpackage

// *** verilog/cer_sync.sv ***
// two flip-flop synchroniser for the external error pin
`timescale 1ns/1ps
module cer_sync (
    // clock and reset
    input wire logic core_clk,
    input wire logic reset_n,
    // level in and out
    input wire logic asyncIn,
    output logic syncOut
);
    typedef struct packed {
        logic meta;
        logic sync;
    } cer_sync_s;

    cer_sync_s st;
    cer_sync_s next_st;

    always_comb begin
        next_st.meta = asyncIn;
        next_st.sync = st.meta;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign syncOut = st.sync;
endmodule
